/* hdl/gptmc_consts.svh */
// gptmc_consts.svh: register offsets, field positions and reset values
// assumes: included by bare name from the package and the design modules
`ifndef GPTMC_CONSTS_SVH
`define GPTMC_CONSTS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define GPTMC_OFS_CFG       12'h000
`define GPTMC_OFS_AMODE     12'h004
`define GPTMC_OFS_BMODE     12'h008
`define GPTMC_OFS_CTL       12'h00c

// ************************************************************
// configuration field encodings
// ************************************************************
`define GPTMC_CFG_W         3
`define GPTMC_CFG_32TIMER   3'h0
`define GPTMC_CFG_32RTC     3'h1

// ************************************************************
// mode register field positions
// ************************************************************
`define GPTMC_MODE_W        4
`define GPTMC_MODE_ALT_BIT  3
`define GPTMC_MODE_CAP_BIT  2
`define GPTMC_MF_ONESHOT    2'h1
`define GPTMC_MF_PERIODIC   2'h2
`define GPTMC_MF_CAPTURE    2'h3

// ************************************************************
// control register layout
// ************************************************************
`define GPTMC_CTL_MASK      32'h00006f7f
`define GPTMC_CTL_B_LSB     8
`define GPTMC_CTL_RTC_BIT   4
`define GPTMC_EDGE_POS      2'h0
`define GPTMC_EDGE_NEG      2'h1
`define GPTMC_EDGE_BOTH     2'h3

// ************************************************************
// reset values
// ************************************************************
`define GPTMC_RST_CFG       3'h0
`define GPTMC_RST_MODE      4'h0
`define GPTMC_RST_CTL       32'h00000000

`endif

/* hdl/gptmc_pkg.sv */
// gptmc_pkg.sv: types shared by the timer control register block
// assumes: gptmc_consts.svh is on the include path
`default_nettype none
package gptmc_pkg;
  `include "gptmc_consts.svh"

  // decoded global configuration
  typedef enum logic [2:0] {
    GPTMC_G_32TIMER = 3'h1,
    GPTMC_G_32RTC   = 3'h2,
    GPTMC_G_SPLIT16 = 3'h4
  } gptmc_gmode_t;

  // decoded function of one half
  typedef enum logic [5:0] {
    GPTMC_F_IDLE     = 6'h01,
    GPTMC_F_ONESHOT  = 6'h02,
    GPTMC_F_PERIODIC = 6'h04,
    GPTMC_F_CAPCOUNT = 6'h08,
    GPTMC_F_CAPTIME  = 6'h10,
    GPTMC_F_PWM      = 6'h20
  } gptmc_func_t;

  // per-half control fields, same order as the control byte
  typedef struct packed {
    logic       pwm_invert;
    logic       trigger_enable;
    logic [1:0] edge_select;
    logic       stall_enable;
    logic       enable;
  } gptmc_half_ctl_t;

  // decoded steering for one half
  typedef struct packed {
    gptmc_func_t func;
    logic        enable;
    logic        stall_enable;
    logic        trigger_enable;
    logic        pwm_invert;
    logic        edge_pos;
    logic        edge_neg;
  } gptmc_half_cfg_t;
endpackage
`default_nettype wire

/* hdl/gptmc_half_decode.sv */
// gptmc_half_decode.sv: turns one half's mode nibble and control fields into steering
// assumes: inputs come straight from registers on the same clock
`default_nettype none
// the guard makes this harmless when the package already pulled it in
`include "gptmc_consts.svh"
module gptmc_half_decode
  import gptmc_pkg::*;
(
  input  wire logic [3:0]      mode,      // stored mode nibble
  input  wire gptmc_half_ctl_t ctl,       // stored control fields
  output gptmc_half_cfg_t      cfg        // decoded steering
);
  // ************************************************************
  // field split
  // ************************************************************
  wire logic [1:0] mode_field   = mode[1:0];
  wire logic       capture_type = mode[`GPTMC_MODE_CAP_BIT];
  wire logic       alt_select   = mode[`GPTMC_MODE_ALT_BIT];

  // pwm needs alt set, capture type clear and periodic field
  wire logic is_pwm = alt_select && !capture_type
                      && (mode_field == `GPTMC_MF_PERIODIC);
  // capture runs only with alt clear and capture field
  wire logic is_cap = !alt_select && (mode_field == `GPTMC_MF_CAPTURE);

  gptmc_func_t func;
  // mode field decode; reserved 0x0 and odd combinations leave the half idle
  always_comb begin
    if (is_pwm) begin
      func = GPTMC_F_PWM;
    end else if (is_cap) begin
      func = capture_type ? GPTMC_F_CAPTIME : GPTMC_F_CAPCOUNT;
    end else if (!alt_select && mode_field == `GPTMC_MF_ONESHOT) begin
      func = GPTMC_F_ONESHOT;
    end else if (!alt_select && mode_field == `GPTMC_MF_PERIODIC) begin
      func = GPTMC_F_PERIODIC;
    end else begin
      func = GPTMC_F_IDLE;
    end
  end

  // edge select: 00 pos, 01 neg, 11 both, 10 reserved answers none
  wire logic e_pos  = (ctl.edge_select == `GPTMC_EDGE_POS);
  wire logic e_neg  = (ctl.edge_select == `GPTMC_EDGE_NEG);
  wire logic e_both = (ctl.edge_select == `GPTMC_EDGE_BOTH);

  assign cfg = '{func:           func,
                 enable:         ctl.enable,
                 stall_enable:   ctl.stall_enable,
                 trigger_enable: ctl.trigger_enable,
                 pwm_invert:     ctl.pwm_invert,
                 edge_pos:       e_pos || e_both,
                 edge_neg:       e_neg || e_both};
endmodule
`default_nettype wire

/* hdl/gptmc_regs.sv */
// gptmc_regs.sv: configuration, mode and control registers of a two-half timer
// assumes: apb master on pclk; counting datapath sits outside and reads the
// decoded steering outputs below
//
// Added by the designer: the APB register port.
`default_nettype none
// the guard makes this harmless when the package already pulled it in
`include "gptmc_consts.svh"
module gptmc_regs
  import gptmc_pkg::*;
(
  input  wire logic        pclk,              // system clock, 50 MHz
  input  wire logic        presetn,           // async reset, active low
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb direction
  input  wire logic [11:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  input  wire logic [3:0]  pstrb,             // apb byte strobes
  output logic      [31:0] prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error
  output gptmc_gmode_t     global_mode,       // decoded global configuration
  output logic             rtc_count_enable,  // rtc counting enabled
  output gptmc_half_cfg_t  half_a_cfg,        // steering for half a
  output gptmc_half_cfg_t  half_b_cfg         // steering for half b
);
  // ************************************************************
  // stored fields
  // ************************************************************
  logic [2:0]  global_config_field;  // configuration field
  logic [3:0]  half_a_mode_reg;      // half a mode nibble
  logic [3:0]  half_b_mode_reg;      // half b mode nibble
  logic [31:0] timer_control_reg;    // control, only writable bits held

  // ************************************************************
  // apb decode
  // ************************************************************
  // zero wait state: the slave answers in the first access cycle
  wire logic setup_ok  = psel && !penable;
  wire logic access    = psel && penable;
  wire logic wr_access = access && pwrite;
  wire logic sel_cfg   = (paddr == `GPTMC_OFS_CFG);
  wire logic sel_amode = (paddr == `GPTMC_OFS_AMODE);
  wire logic sel_bmode = (paddr == `GPTMC_OFS_BMODE);
  wire logic sel_ctl   = (paddr == `GPTMC_OFS_CTL);
  wire logic sel_any   = sel_cfg || sel_amode || sel_bmode || sel_ctl;

  // byte-lane merge; bits outside the writable mask never change
  wire logic [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                                 {8{pstrb[1]}}, {8{pstrb[0]}}};
  wire logic [31:0] ctl_merge = ((timer_control_reg & ~lane_mask)
                                 | (pwdata & lane_mask)) & `GPTMC_CTL_MASK;

  assign pready  = 1'h1;
  // an unmapped address completes with an error and stores nothing
  assign pslverr = access && !sel_any;

  // ************************************************************
  // register writes
  // ************************************************************
  // all fields clear under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_config_field <= `GPTMC_RST_CFG;
      half_a_mode_reg     <= `GPTMC_RST_MODE;
      half_b_mode_reg     <= `GPTMC_RST_MODE;
      timer_control_reg   <= `GPTMC_RST_CTL;
    end else if (wr_access && pstrb[0]) begin
      // only low lane carries cfg and mode fields
      if (sel_cfg) begin
        global_config_field <= pwdata[2:0];
      end else if (sel_amode) begin
        half_a_mode_reg <= pwdata[3:0];
      end else if (sel_bmode) begin
        half_b_mode_reg <= pwdata[3:0];
      end else if (sel_ctl) begin
        timer_control_reg <= ctl_merge;
      end
    end else if (wr_access && sel_ctl) begin
      // high lane only: half b fields
      timer_control_reg <= ctl_merge;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // reads are pure: no field changes on a read
  wire logic [31:0] rd_mux =
    sel_cfg   ? {29'h0000000, global_config_field} :
    sel_amode ? {28'h0000000, half_a_mode_reg}     :
    sel_bmode ? {28'h0000000, half_b_mode_reg}     :
    sel_ctl   ? timer_control_reg                  : 32'h00000000;

  // data output from a flop, loaded in the setup cycle for the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_ok && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ************************************************************
  // global configuration decode
  // ************************************************************
  // reserved 0x2/0x3 are left to software to avoid; treated as 32-bit timer
  always_comb begin
    if (global_config_field[2]) begin
      global_mode = GPTMC_G_SPLIT16;
    end else if (global_config_field == `GPTMC_CFG_32RTC) begin
      global_mode = GPTMC_G_32RTC;
    end else begin
      global_mode = GPTMC_G_32TIMER;
    end
  end

  wire logic split16 = (global_mode == GPTMC_G_SPLIT16);

  assign rtc_count_enable = timer_control_reg[`GPTMC_CTL_RTC_BIT];

  // ************************************************************
  // per-half decode
  // ************************************************************
  gptmc_half_ctl_t a_ctl;  // half a fields, low byte
  gptmc_half_ctl_t b_ctl;  // half b fields, next byte
  assign a_ctl = '{pwm_invert:     timer_control_reg[6],
                   trigger_enable: timer_control_reg[5],
                   edge_select:    timer_control_reg[3:2],
                   stall_enable:   timer_control_reg[1],
                   enable:         timer_control_reg[0]};
  assign b_ctl = '{pwm_invert:     timer_control_reg[14],
                   trigger_enable: timer_control_reg[13],
                   edge_select:    timer_control_reg[11:10],
                   stall_enable:   timer_control_reg[9],
                   enable:         timer_control_reg[8]};

  // in 32-bit configuration half b follows half a's mode
  wire logic [3:0] b_mode_used = split16 ? half_b_mode_reg : half_a_mode_reg;

  gptmc_half_decode u_dec_a (
    .mode (half_a_mode_reg),
    .ctl  (a_ctl),
    .cfg  (half_a_cfg)
  );

  gptmc_half_decode u_dec_b (
    .mode (b_mode_used),
    .ctl  (b_ctl),
    .cfg  (half_b_cfg)
  );

  // ************************************************************
  // checks
  // ************************************************************
  AST_CFG_ZERO_32: assert property (@(posedge pclk) disable iff (!presetn)
    (global_config_field == 3'h0) |-> (global_mode == GPTMC_G_32TIMER))
    else $error("config 0 did not give 32-bit timer");

  AST_CFG_ONE_RTC: assert property (@(posedge pclk) disable iff (!presetn)
    (global_config_field == 3'h1) |-> (global_mode == GPTMC_G_32RTC))
    else $error("config 1 did not give rtc");

  AST_CFG_SPLIT: assert property (@(posedge pclk) disable iff (!presetn)
    global_config_field[2] |-> (global_mode == GPTMC_G_SPLIT16))
    else $error("config 4-7 did not split");

  AST_CFG_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_cfg && pstrb[0]) |=> (global_config_field == $past(pwdata[2:0])))
    else $error("config write lost");

  AST_CTL_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_control_reg & ~`GPTMC_CTL_MASK) == 32'h00000000)
    else $error("reserved control bit set");

  AST_PWM_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
    (half_a_mode_reg == 4'ha) |-> (half_a_cfg.func == GPTMC_F_PWM))
    else $error("pwm decode wrong");

  AST_CAP_TIME: assert property (@(posedge pclk) disable iff (!presetn)
    (half_a_mode_reg == 4'h7) |-> (half_a_cfg.func == GPTMC_F_CAPTIME))
    else $error("edge-time decode wrong");

  AST_ONESHOT: assert property (@(posedge pclk) disable iff (!presetn)
    (half_a_mode_reg == 4'h1) |-> (half_a_cfg.func == GPTMC_F_ONESHOT))
    else $error("oneshot decode wrong");

  AST_B_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
    !split16 |-> (half_b_cfg.func == half_a_cfg.func))
    else $error("half b mode not ignored in 32-bit");

  AST_B_ENABLE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_ctl && pstrb[1]) |=> (half_b_cfg.enable == $past(pwdata[8])))
    else $error("half b enable not written");

  AST_B_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_control_reg[11:10] == 2'h2) |-> !(half_b_cfg.edge_pos || half_b_cfg.edge_neg))
    else $error("reserved edge code selected an edge");

  AST_RTC_EN: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_ctl && pstrb[0]) |=> (rtc_count_enable == $past(pwdata[4])))
    else $error("rtc enable not written");

  AST_READ_CLEAN: assert property (@(posedge pclk) disable iff (!presetn)
    (access && !pwrite) |=> $stable(timer_control_reg) && $stable(global_config_field))
    else $error("read changed a register");

  // ************************************************************
  // checks on decoded modes and written fields
  // ************************************************************
  // remaining mode field codes of half a
  AST_PERIODIC: assert property (@(posedge pclk) disable iff (!presetn)
    (half_a_mode_reg == 4'h2) |-> (half_a_cfg.func == GPTMC_F_PERIODIC))
    else $error("periodic decode wrong");

  AST_CAP_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
    (half_a_mode_reg == 4'h3) |-> (half_a_cfg.func == GPTMC_F_CAPCOUNT))
    else $error("edge-count decode wrong");

  // in split configuration half b must follow its own nibble, not half a's
  AST_B_OWN_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    (split16 && (half_b_mode_reg == 4'h7)) |-> (half_b_cfg.func == GPTMC_F_CAPTIME))
    else $error("half b own mode not used");

  AST_B_PWM: assert property (@(posedge pclk) disable iff (!presetn)
    (split16 && (half_b_mode_reg == 4'ha)) |-> (half_b_cfg.func == GPTMC_F_PWM))
    else $error("half b pwm decode wrong");

  AST_BMODE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_bmode && pstrb[0]) |=> (half_b_mode_reg == $past(pwdata[3:0])))
    else $error("half b mode write lost");

  // half b control bits land on the matching steering outputs
  AST_B_INVERT: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_ctl && pstrb[1]) |=> (half_b_cfg.pwm_invert == $past(pwdata[14])))
    else $error("half b pwm invert not written");

  AST_B_TRIGGER: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_ctl && pstrb[1]) |=> (half_b_cfg.trigger_enable == $past(pwdata[13])))
    else $error("half b trigger not written");

  AST_B_STALL: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_ctl && pstrb[1]) |=> (half_b_cfg.stall_enable == $past(pwdata[9])))
    else $error("half b stall not written");

  AST_B_NEG: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_control_reg[11:10] == 2'h1) |-> (half_b_cfg.edge_neg && !half_b_cfg.edge_pos))
    else $error("half b negative edge wrong");

  // half a fields sit in the low byte in the same order
  AST_A_FIELDS: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_ctl && pstrb[0]) |=>
      ((half_a_cfg.enable == $past(pwdata[0])) && (half_a_cfg.stall_enable == $past(pwdata[1]))
       && (half_a_cfg.trigger_enable == $past(pwdata[5]))
       && (half_a_cfg.pwm_invert == $past(pwdata[6]))))
    else $error("half a control fields not written");

  AST_A_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_control_reg[3:2] == 2'h3) |-> (half_a_cfg.edge_pos && half_a_cfg.edge_neg))
    else $error("half a both edges wrong");

  // byte strobes: an unstrobed lane keeps what it held
  AST_CFG_STRB: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_cfg && !pstrb[0]) |=> $stable(global_config_field))
    else $error("config changed without its lane");

  AST_CTL_LANE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && sel_ctl && !pstrb[1]) |=> (timer_control_reg[15:8] == $past(timer_control_reg[15:8])))
    else $error("control high byte changed without its lane");

  // an unmapped write must not alias onto any register
  AST_NO_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_access && !sel_any) |=> ($stable(timer_control_reg) && $stable(global_config_field)
                                 && $stable(half_a_mode_reg) && $stable(half_b_mode_reg)))
    else $error("unmapped write stored a field");

  // read data is the stored field, taken in the setup cycle
  AST_READ_CFG: assert property (@(posedge pclk) disable iff (!presetn)
    (setup_ok && !pwrite && sel_cfg) |=> (prdata == {29'h0000000, $past(global_config_field)}))
    else $error("config read data wrong");

  // no disable here: this one watches the reset itself; one edge of reset
  // is enough for every field to read zero at the next edge
  AST_RESET_ZERO: assert property (@(posedge pclk)
    !presetn |=> ((global_config_field == 3'h0) && (half_a_mode_reg == 4'h0)
                  && (half_b_mode_reg == 4'h0) && (timer_control_reg == 32'h00000000)
                  && (prdata == 32'h00000000)))
    else $error("field not zero after reset");
endmodule
`default_nettype wire

/* verification/gptmc_regs_tb.sv */
// gptmc_regs_tb.sv: self-checking bench for the timer mode and control registers
// assumes: package, header and design compiled first; bench is the only apb master
`default_nettype none
module gptmc_regs_tb
  import gptmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // signals and table
  // ************************************************************
  logic            pclk;              // 50 MHz system clock
  logic            presetn;           // async reset, active low
  logic            psel;              // apb select
  logic            penable;           // apb access phase
  logic            pwrite;            // apb direction
  logic [11:0]     paddr;             // apb byte address
  logic [31:0]     pwdata;            // apb write data
  logic [3:0]      pstrb;             // apb byte strobes
  logic [31:0]     prdata;            // apb read data
  logic            pready;            // apb ready
  logic            pslverr;           // apb error
  gptmc_gmode_t    global_mode;       // decoded configuration
  logic            rtc_count_enable;  // rtc counting
  gptmc_half_cfg_t half_a_cfg;        // half a steering
  gptmc_half_cfg_t half_b_cfg;        // half b steering
  int              err_total;         // mismatches seen
  int              n_checks;          // comparisons made

  // one row: values written, decoded functions expected
  typedef struct {
    logic [2:0]   cfg;
    logic [3:0]   amode;
    logic [3:0]   bmode;
    logic [31:0]  ctl;
    gptmc_gmode_t gm;
    gptmc_func_t  fa;
    gptmc_func_t  fb;
  } gptmc_row_t;

  // reserved configs and mode field 0 are left out, software never writes them
  gptmc_row_t rows [9] = '{
    '{3'h0, 4'h1, 4'h2, 32'h00000000, GPTMC_G_32TIMER, GPTMC_F_ONESHOT, GPTMC_F_ONESHOT},
    '{3'h1, 4'h2, 4'h3, 32'hffffffff, GPTMC_G_32RTC, GPTMC_F_PERIODIC, GPTMC_F_PERIODIC},
    '{3'h4, 4'h1, 4'h2, 32'h00002a55, GPTMC_G_SPLIT16, GPTMC_F_ONESHOT, GPTMC_F_PERIODIC},
    '{3'h7, 4'h3, 4'h7, 32'h00004521, GPTMC_G_SPLIT16, GPTMC_F_CAPCOUNT, GPTMC_F_CAPTIME},
    '{3'h5, 4'ha, 4'h1, 32'h00006f7f, GPTMC_G_SPLIT16, GPTMC_F_PWM, GPTMC_F_ONESHOT},
    '{3'h6, 4'h2, 4'h3, 32'h00000935, GPTMC_G_SPLIT16, GPTMC_F_PERIODIC, GPTMC_F_CAPCOUNT},
    '{3'h0, 4'h7, 4'h3, 32'h00002b4a, GPTMC_G_32TIMER, GPTMC_F_CAPTIME, GPTMC_F_CAPTIME},
    '{3'h1, 4'ha, 4'h1, 32'h00004616, GPTMC_G_32RTC, GPTMC_F_PWM, GPTMC_F_PWM},
    '{3'h4, 4'h3, 4'ha, 32'h00000c08, GPTMC_G_SPLIT16, GPTMC_F_CAPCOUNT, GPTMC_F_PWM}
  };

  gptmc_regs i_dut (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .pstrb            (pstrb),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .global_mode      (global_mode),
    .rtc_count_enable (rtc_count_enable),
    .half_a_cfg       (half_a_cfg),
    .half_b_cfg       (half_b_cfg)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  // expected steering from a function and one control byte; edge code 10 picks no edge
  function automatic gptmc_half_cfg_t exp_half(input gptmc_func_t f, input logic [6:0] b);
    return '{func: f, enable: b[0], stall_enable: b[1], trigger_enable: b[5],
             pwm_invert: b[6], edge_pos: (b[3:2] == 2'h0) || (b[3:2] == 2'h3),
             edge_neg: (b[3:2] == 2'h1) || (b[3:2] == 2'h3)};
  endfunction

  // verdict and end of run, also reached from a timeout
  task automatic stop_test;
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // register words and bus flags
  task automatic cmp_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // decoded steering outputs
  task automatic cmp_steer(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one transfer, entered just after an edge; request stays up so the next can follow at once
  task automatic apb_xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdat,
                          input logic [3:0] strb, output logic [31:0] rdat);
    int   n;
    logic exp_err;
    exp_err = !(addr inside {12'h000, 12'h004, 12'h008, 12'h00c});
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wdat;
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      stop_test();
    end
    rdat = prdata;
    cmp_reg("pslverr", {31'h0, exp_err}, {31'h0, pslverr});
  endtask

  task automatic apb_wr(input logic [11:0] addr, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] dummy;
    apb_xfer(1'b1, addr, d, s, dummy);
  endtask

  task automatic rd_chk(input string what, input logic [11:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    apb_xfer(1'b0, addr, 32'h0, 4'h0, rd);
    cmp_reg(what, exp, rd);
  endtask

  // ************************************************************
  // clock and main sequence
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  initial begin
    presetn   = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 12'h000;
    pwdata    = 32'h0;
    pstrb     = 4'h0;
    err_total = 0;
    n_checks  = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // table rows, all transfers back to back; reserved cfg and mode bits written as ones
    foreach (rows[i]) begin
      apb_wr(12'h00c, 32'h0, 4'hf);
      apb_wr(12'h000, {29'h1fffffff, rows[i].cfg}, 4'hf);
      apb_wr(12'h004, {28'hfffffff, rows[i].amode}, 4'hf);
      apb_wr(12'h008, {28'hfffffff, rows[i].bmode}, 4'hf);
      apb_wr(12'h00c, rows[i].ctl, 4'hf);
      rd_chk("cfg", 12'h000, {29'h0, rows[i].cfg});
      rd_chk("amode", 12'h004, {28'h0, rows[i].amode});
      rd_chk("bmode", 12'h008, {28'h0, rows[i].bmode});
      rd_chk("ctl", 12'h00c, rows[i].ctl & 32'h00006f7f);
      cmp_steer("global_mode", {13'h0, rows[i].gm}, {13'h0, global_mode});
      cmp_steer("half_a_cfg", {4'h0, exp_half(rows[i].fa, rows[i].ctl[6:0])},
                {4'h0, half_a_cfg});
      cmp_steer("half_b_cfg", {4'h0, exp_half(rows[i].fb, rows[i].ctl[14:8])},
                {4'h0, half_b_cfg});
      cmp_steer("rtc_count_enable", {15'h0, rows[i].ctl[4]}, {15'h0, rtc_count_enable});
    end
    // byte strobes: only the strobed control byte changes, cfg needs its low byte
    apb_wr(12'h00c, 32'h00006f7f, 4'hf);
    apb_wr(12'h00c, 32'h00000000, 4'h1);
    rd_chk("ctl strobed", 12'h00c, 32'h00006f00);
    apb_wr(12'h000, 32'h00000001, 4'he);
    rd_chk("cfg strobed", 12'h000, {29'h0, rows[8].cfg});
    // unmapped address: refused, stores nothing, reads zero
    apb_wr(12'h010, 32'hffffffff, 4'hf);
    rd_chk("unmapped", 12'h010, 32'h0);
    rd_chk("ctl after unmapped", 12'h00c, 32'h00006f00);
    // reset in mid-run with fields set
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp_steer("reset global_mode", 16'h0001, {13'h0, global_mode});
    cmp_steer("reset half_a_cfg", {4'h0, exp_half(GPTMC_F_IDLE, 7'h0)},
              {4'h0, half_a_cfg});
    cmp_steer("reset half_b_cfg", {4'h0, exp_half(GPTMC_F_IDLE, 7'h0)},
              {4'h0, half_b_cfg});
    cmp_steer("reset rtc", 16'h0, {15'h0, rtc_count_enable});
    presetn <= 1'b1;
    @(posedge pclk);
    for (int k = 0; k < 4; k++) begin
      rd_chk("reset value", 12'(k * 4), 32'h0);
    end
    stop_test();
  end
endmodule
`default_nettype wire
